// >>> ilofir_monitor.sv
// Port checker for the I/O line register block
module ilofir_monitor #(
   parameter logic [31:0] LINE_MASK = 32'hFFFFFFFF,
   parameter logic [15:0] FILT_DIV = 16'h0004
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] pad_in,
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_oe,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire wdone = pready & pwrite;
   wire rdone = pready & ~pwrite;

   ////////////////////////////////////////////////////////////////////////////
   property p_ack;
      psel && penable && !pready |=> pready;
   endproperty
   a_ack: assert property (p_ack) else $error("no ready after access");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held too long");
   property p_oe_set;
      wdone && paddr == 8'h10 |=> pad_oe == ($past(pad_oe) | ($past(pwdata) & LINE_MASK));
   endproperty
   a_oe_set: assert property (p_oe_set) else $error("enable set wrong");
   property p_oe_clr;
      wdone && paddr == 8'h14 |=> pad_oe == ($past(pad_oe) & ~$past(pwdata));
   endproperty
   a_oe_clr: assert property (p_oe_clr) else $error("enable clear wrong");
   property p_lvl_set;
      wdone && paddr == 8'h30 |=> pad_out == ($past(pad_out) | ($past(pwdata) & LINE_MASK));
   endproperty
   a_lvl_set: assert property (p_lvl_set) else $error("level set wrong");
   property p_lvl_clr;
      wdone && paddr == 8'h34 |=> pad_out == ($past(pad_out) & ~$past(pwdata));
   endproperty
   a_lvl_clr: assert property (p_lvl_clr) else $error("level clear wrong");
   // Driver enables move only through their own two registers
   property p_oe_quiet;
      !$stable(pad_oe) |-> $past(wdone) && ($past(paddr) == 8'h10 || $past(paddr) == 8'h14);
   endproperty
   a_oe_quiet: assert property (p_oe_quiet) else $error("enable moved alone");
   property p_rd_oe;
      rdone && paddr == 8'h18 |-> prdata == pad_oe;
   endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("enable state mismatch");
   property p_rd_lvl;
      rdone && paddr == 8'h38 |-> prdata == pad_out;
   endproperty
   a_rd_lvl: assert property (p_rd_lvl) else $error("level state mismatch");
   property p_rd_zero;
      rdone |-> (prdata & ~LINE_MASK) == 32'h00000000;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("absent line reads one");
endmodule : ilofir_monitor

bind ilofir_top ilofir_monitor #(.LINE_MASK(LINE_MASK), .FILT_DIV(FILT_DIV)) u_mon (
   .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .irq(irq)
);

// >>> ilofir_pads.sv
// Line-side model: external drivers on the I/O pads
module ilofir_pads (
   input wire logic [31:0] pad_out,
   input wire logic [31:0] pad_oe,
   input wire logic [31:0] ext_level,
   output logic [31:0] pad_in
);
   // Controller wins where its driver is on
   assign pad_in = (pad_out & pad_oe) | (ext_level & ~pad_oe);
endmodule : ilofir_pads

// >>> ilofir_pkg.sv
// Types shared by the I/O line block
package ilofir_pkg;

   typedef logic [31:0] ilofir_word_t;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      ilofir_word_t wdata;
   } ilofir_apb_req_t;

   typedef struct packed {
      ilofir_word_t level;
      ilofir_word_t enable;
   } ilofir_pad_drive_t;

   typedef enum logic [1:0] {
      ILOFIR_BUS_IDLE = 2'b01,
      ILOFIR_BUS_RESP = 2'b10
   } ilofir_bus_st_t;

endpackage : ilofir_pkg

// >>> ilofir_regs.svh
// Register offsets, reset values and default counts of the I/O line block
`ifndef ILOFIR_REGS_SVH
`define ILOFIR_REGS_SVH

`define ILOFIR_OFS_OE_SET 8'h10
`define ILOFIR_OFS_OE_CLR 8'h14
`define ILOFIR_OFS_OE_STATE 8'h18
`define ILOFIR_OFS_GF_SET 8'h20
`define ILOFIR_OFS_GF_CLR 8'h24
`define ILOFIR_OFS_GF_STATE 8'h28
`define ILOFIR_OFS_DL_SET 8'h30
`define ILOFIR_OFS_DL_CLR 8'h34
`define ILOFIR_OFS_DL_STATE 8'h38
`define ILOFIR_OFS_PIN_STATE 8'h3C
`define ILOFIR_OFS_IE_SET 8'h40
`define ILOFIR_OFS_IE_CLR 8'h44
`define ILOFIR_OFS_IE_MASK 8'h48
`define ILOFIR_OFS_EVT_STATUS 8'h4C
`define ILOFIR_OFS_WG_SET 8'hA0
`define ILOFIR_OFS_WG_CLR 8'hA4
`define ILOFIR_OFS_WG_STATE 8'hA8

`define ILOFIR_ZERO 32'h00000000
`define ILOFIR_LINE_MASK 32'hFFFFFFFF
`define ILOFIR_FILT_DIV 16'h0004
`define ILOFIR_CNT_ZERO 16'h0000
`define ILOFIR_CNT_ONE 16'h0001

`endif

// >>> ilofir_top.sv
// Per-line output, glitch filter and input change interrupt registers on APB
`include "ilofir_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1: One in enable-set turns line driver on
// RULE2: One in enable-clear turns line driver off
// RULE3: Enable state reads one while driver on
// RULE4: One in filter-set enables line glitch filter
// RULE5: One in filter-clear disables line glitch filter
// RULE6: Filter state reads one while filter enabled
// RULE7: One in level-set schedules line high
// RULE8: One in level-clear schedules line low
// RULE9: Level state returns scheduled drive level
// RULE10: Level state always readable, optionally writable
// RULE11: Pin state returns sampled line level
// RULE12: One in irq-set enables change interrupt
// RULE13: One in irq-clear disables change interrupt
// RULE14: Mask state reads one while interrupt enabled
// RULE15: All registers 32 bits, bit n line n
// RULE16: Unimplemented lines ignore writes, read zero
// RULE17: Change status sticky until status read or written with ones
// RULE18: Interrupt while status and mask both set
// RULE19: Direct level writes only on gated lines
module ilofir_top #(
   parameter logic [31:0] LINE_MASK = `ILOFIR_LINE_MASK,
   parameter logic [15:0] FILT_DIV = `ILOFIR_FILT_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] pad_in,
   output logic [31:0] pad_out,
   output logic [31:0] pad_oe,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
      addr_hit = (addr[7:2] == ofs[7:2]);
   endfunction : addr_hit

   function automatic ilofir_pkg::ilofir_word_t set_clr(
      input ilofir_pkg::ilofir_word_t cur,
      input ilofir_pkg::ilofir_word_t set_bits,
      input ilofir_pkg::ilofir_word_t clr_bits
   );
      set_clr = (cur | set_bits) & ~clr_bits;
   endfunction : set_clr

   ////////////////////////////////////////////////////////////////////////////
   // State

   ilofir_pkg::ilofir_bus_st_t bus_st;
   ilofir_pkg::ilofir_apb_req_t req;
   ilofir_pkg::ilofir_pad_drive_t drive;
   ilofir_pkg::ilofir_word_t filter_en;
   ilofir_pkg::ilofir_word_t irq_en;
   ilofir_pkg::ilofir_word_t write_gate;
   ilofir_pkg::ilofir_word_t change_status;
   ilofir_pkg::ilofir_word_t pin_sample;
   ilofir_pkg::ilofir_word_t filt_sample;
   ilofir_pkg::ilofir_word_t filt_level;
   ilofir_pkg::ilofir_word_t seen_prev;
   ilofir_pkg::ilofir_word_t read_snap;
   logic seen_valid;
   logic [15:0] filt_cnt;
   logic filt_tick;

   ilofir_pkg::ilofir_word_t wdata_m;
   ilofir_pkg::ilofir_word_t next_rdata;
   ilofir_pkg::ilofir_word_t next_seen;
   ilofir_pkg::ilofir_word_t change_now;
   ilofir_pkg::ilofir_word_t status_clr;
   ilofir_pkg::ilofir_word_t next_status;
   ilofir_pkg::ilofir_word_t filt_stable;
   logic next_mapped;
   logic wr_done;
   logic rd_done;
   logic access_first;
   logic wr_oe_set;
   logic wr_oe_clr;
   logic wr_gf_set;
   logic wr_gf_clr;
   logic wr_dl_set;
   logic wr_dl_clr;
   logic wr_dl_state;
   logic wr_wg_set;
   logic wr_wg_clr;
   logic wr_ie_set;
   logic wr_ie_clr;
   logic wr_evt;
   logic rd_evt;

   ////////////////////////////////////////////////////////////////////////////
   // APB request and completion

   assign req.addr = paddr;
   assign req.write = pwrite;
   assign req.wdata = pwdata;

   // Bits of lines that do not exist are dropped before any register sees them
   assign wdata_m = req.wdata & LINE_MASK; // RULE15 RULE16

   // A transfer completes on the edge where pready is already high
   assign wr_done = psel && penable && pready && req.write;
   assign rd_done = psel && penable && pready && !req.write;

   // First access cycle of a transfer; the answer is built here
   assign access_first = bus_st == ilofir_pkg::ILOFIR_BUS_IDLE && psel && penable;

   always_ff @(posedge clk) begin
      if (rst) begin
         bus_st <= ilofir_pkg::ILOFIR_BUS_IDLE;
      end else begin
         unique case (bus_st)
            ilofir_pkg::ILOFIR_BUS_IDLE: begin
               if (psel && penable) begin
                  bus_st <= ilofir_pkg::ILOFIR_BUS_RESP;
               end
            end
            ilofir_pkg::ILOFIR_BUS_RESP: begin
               bus_st <= ilofir_pkg::ILOFIR_BUS_IDLE;
            end
            default: begin
               bus_st <= ilofir_pkg::ILOFIR_BUS_IDLE;
            end
         endcase
      end
   end

   // One wait state: data is latched in the first access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `ILOFIR_ZERO;
      end else if (access_first) begin
         pready <= 1'b1;
         pslverr <= !next_mapped;
         prdata <= req.write ? `ILOFIR_ZERO : next_rdata;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `ILOFIR_ZERO;
      end
   end

   // Snapshot of the status bits actually returned, so only those get cleared
   always_ff @(posedge clk) begin
      if (rst) begin
         read_snap <= `ILOFIR_ZERO;
      end else if (access_first && !req.write && addr_hit(req.addr, `ILOFIR_OFS_EVT_STATUS)) begin
         read_snap <= change_status;
      end else if (!pready) begin
         read_snap <= `ILOFIR_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register strobes, decoded once so each view has a single condition

   assign wr_oe_set = wr_done && addr_hit(req.addr, `ILOFIR_OFS_OE_SET);
   assign wr_oe_clr = wr_done && addr_hit(req.addr, `ILOFIR_OFS_OE_CLR);
   assign wr_gf_set = wr_done && addr_hit(req.addr, `ILOFIR_OFS_GF_SET);
   assign wr_gf_clr = wr_done && addr_hit(req.addr, `ILOFIR_OFS_GF_CLR);
   assign wr_dl_set = wr_done && addr_hit(req.addr, `ILOFIR_OFS_DL_SET);
   assign wr_dl_clr = wr_done && addr_hit(req.addr, `ILOFIR_OFS_DL_CLR);
   assign wr_dl_state = wr_done && addr_hit(req.addr, `ILOFIR_OFS_DL_STATE);
   assign wr_wg_set = wr_done && addr_hit(req.addr, `ILOFIR_OFS_WG_SET);
   assign wr_wg_clr = wr_done && addr_hit(req.addr, `ILOFIR_OFS_WG_CLR);
   assign wr_ie_set = wr_done && addr_hit(req.addr, `ILOFIR_OFS_IE_SET);
   assign wr_ie_clr = wr_done && addr_hit(req.addr, `ILOFIR_OFS_IE_CLR);
   assign wr_evt = wr_done && addr_hit(req.addr, `ILOFIR_OFS_EVT_STATUS);
   assign rd_evt = rd_done && addr_hit(req.addr, `ILOFIR_OFS_EVT_STATUS);

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   always_comb begin
      next_rdata = `ILOFIR_ZERO;
      next_mapped = 1'b1;
      if (addr_hit(req.addr, `ILOFIR_OFS_OE_SET) || addr_hit(req.addr, `ILOFIR_OFS_OE_CLR)
          || addr_hit(req.addr, `ILOFIR_OFS_GF_SET) || addr_hit(req.addr, `ILOFIR_OFS_GF_CLR)
          || addr_hit(req.addr, `ILOFIR_OFS_DL_SET) || addr_hit(req.addr, `ILOFIR_OFS_DL_CLR)
          || addr_hit(req.addr, `ILOFIR_OFS_IE_SET) || addr_hit(req.addr, `ILOFIR_OFS_IE_CLR)
          || addr_hit(req.addr, `ILOFIR_OFS_WG_SET) || addr_hit(req.addr, `ILOFIR_OFS_WG_CLR)) begin
         // Write-only views read as zero
         next_rdata = `ILOFIR_ZERO;
      end else if (addr_hit(req.addr, `ILOFIR_OFS_OE_STATE)) begin
         next_rdata = drive.enable; // RULE3
      end else if (addr_hit(req.addr, `ILOFIR_OFS_GF_STATE)) begin
         next_rdata = filter_en; // RULE6
      end else if (addr_hit(req.addr, `ILOFIR_OFS_DL_STATE)) begin
         next_rdata = drive.level; // RULE9 RULE10
      end else if (addr_hit(req.addr, `ILOFIR_OFS_PIN_STATE)) begin
         next_rdata = pin_sample; // RULE11
      end else if (addr_hit(req.addr, `ILOFIR_OFS_IE_MASK)) begin
         next_rdata = irq_en; // RULE14
      end else if (addr_hit(req.addr, `ILOFIR_OFS_EVT_STATUS)) begin
         next_rdata = change_status;
      end else if (addr_hit(req.addr, `ILOFIR_OFS_WG_STATE)) begin
         next_rdata = write_gate;
      end else begin
         next_mapped = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output driver enable

   always_ff @(posedge clk) begin
      if (rst) begin
         drive.enable <= `ILOFIR_ZERO;
      end else if (wr_oe_set) begin
         drive.enable <= set_clr(drive.enable, wdata_m, `ILOFIR_ZERO); // RULE1
      end else if (wr_oe_clr) begin
         drive.enable <= set_clr(drive.enable, `ILOFIR_ZERO, wdata_m); // RULE2
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scheduled drive level

   always_ff @(posedge clk) begin
      if (rst) begin
         drive.level <= `ILOFIR_ZERO;
      end else if (wr_dl_set) begin
         drive.level <= set_clr(drive.level, wdata_m, `ILOFIR_ZERO); // RULE7
      end else if (wr_dl_clr) begin
         drive.level <= set_clr(drive.level, `ILOFIR_ZERO, wdata_m); // RULE8
      end else if (wr_dl_state) begin
         // Ungated lines keep their level, so the view acts read-only for them
         drive.level <= (drive.level & ~write_gate) | (wdata_m & write_gate); // RULE10 RULE19
      end
   end

   // Per-line gate for direct level writes
   always_ff @(posedge clk) begin
      if (rst) begin
         write_gate <= `ILOFIR_ZERO;
      end else if (wr_wg_set) begin
         write_gate <= set_clr(write_gate, wdata_m, `ILOFIR_ZERO); // RULE19
      end else if (wr_wg_clr) begin
         write_gate <= set_clr(write_gate, `ILOFIR_ZERO, wdata_m); // RULE19
      end
   end

   // Pads follow the registers directly, no extra stage
   assign pad_out = drive.level;
   assign pad_oe = drive.enable;

   ////////////////////////////////////////////////////////////////////////////
   // Glitch filter enable

   always_ff @(posedge clk) begin
      if (rst) begin
         filter_en <= `ILOFIR_ZERO;
      end else if (wr_gf_set) begin
         filter_en <= set_clr(filter_en, wdata_m, `ILOFIR_ZERO); // RULE4
      end else if (wr_gf_clr) begin
         filter_en <= set_clr(filter_en, `ILOFIR_ZERO, wdata_m); // RULE5
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input sampling and filtering

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_sample <= `ILOFIR_ZERO;
      end else begin
         pin_sample <= pad_in & LINE_MASK; // RULE11 RULE16
      end
   end

   // Filter sample rate; a divide of one ticks every cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         filt_cnt <= `ILOFIR_CNT_ZERO;
         filt_tick <= 1'b0;
      end else if (filt_cnt + `ILOFIR_CNT_ONE >= FILT_DIV) begin
         filt_cnt <= `ILOFIR_CNT_ZERO;
         filt_tick <= 1'b1;
      end else begin
         filt_cnt <= filt_cnt + `ILOFIR_CNT_ONE;
         filt_tick <= 1'b0;
      end
   end

   // A level must agree on two ticks in a row; shorter pulses are dropped
   assign filt_stable = ~(pin_sample ^ filt_sample);

   always_ff @(posedge clk) begin
      if (rst) begin
         filt_sample <= `ILOFIR_ZERO;
         filt_level <= `ILOFIR_ZERO;
      end else if (filt_tick) begin
         filt_sample <= pin_sample;
         filt_level <= (filt_level & ~filt_stable) | (pin_sample & filt_stable);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input change detection

   assign next_seen = (filter_en & filt_level) | (~filter_en & pin_sample);

   // First cycle after reset only primes the history, the pad level is unknown
   assign change_now = seen_valid ? ((next_seen ^ seen_prev) & LINE_MASK) : `ILOFIR_ZERO;

   always_ff @(posedge clk) begin
      if (rst) begin
         seen_prev <= `ILOFIR_ZERO;
         seen_valid <= 1'b0;
      end else begin
         seen_prev <= next_seen;
         seen_valid <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Change status and interrupt

   always_comb begin
      status_clr = `ILOFIR_ZERO;
      if (rd_evt) begin
         status_clr = read_snap; // RULE17
      end else if (wr_evt) begin
         status_clr = wdata_m;
      end
   end

   // A change in the clearing cycle survives
   assign next_status = set_clr(change_status, `ILOFIR_ZERO, status_clr) | change_now; // RULE17

   always_ff @(posedge clk) begin
      if (rst) begin
         change_status <= `ILOFIR_ZERO;
      end else begin
         change_status <= next_status;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_en <= `ILOFIR_ZERO;
      end else if (wr_ie_set) begin
         irq_en <= set_clr(irq_en, wdata_m, `ILOFIR_ZERO); // RULE12
      end else if (wr_ie_clr) begin
         irq_en <= set_clr(irq_en, `ILOFIR_ZERO, wdata_m); // RULE13
      end
   end

   // Registered, so it trails the status register by one cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(change_status & irq_en); // RULE18
      end
   end

endmodule : ilofir_top

// >>> io_line_output_filter_irq_regs_tb.sv
// Bench for the I/O line register block over APB
module io_line_output_filter_irq_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] ext_level = 32'h00000000;
   logic [31:0] prdata, pad_in, pad_out, pad_oe, r;
   logic pready, pslverr, irq, e;
   logic [7:0] ro [6] = '{8'h18, 8'h28, 8'h38, 8'h3C, 8'h48, 8'h4C};
   int n_errors = 0;
   int n_compared = 0;
   always #25 clk = ~clk;
   // Top byte of lines left out to reach the absent-line logic
   ilofir_top #(.LINE_MASK(32'h00FFFFFF)) dut (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .irq(irq));
   ilofir_pads pads (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
      .pad_in(pad_in));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge clk);
      end
      chk({31'h0, pready}, 32'h00000001);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      acc(a, 1'b0, 32'h00000000);
      chk(r, x);
   endtask : rd
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (ro[i]) rd(ro[i], 32'h00000000);
      $display("test reset done");
      wr(8'h10, 32'hFFFF0001);
      rd(8'h18, 32'h00FF0001);
      chk({31'h0, e}, 32'h00000000);
      wr(8'h10, 32'h00000000);
      wr(8'h14, 32'h00000001);
      wr(8'h18, 32'h00000000);
      rd(8'h18, 32'h00FF0000);
      chk(pad_oe, 32'h00FF0000);
      $display("test drive enable done");
      wr(8'h20, 32'h000000F0);
      wr(8'h24, 32'h00000030);
      rd(8'h28, 32'h000000C0);
      $display("test filter done");
      wr(8'h30, 32'h0001000F);
      wr(8'h34, 32'h00000005);
      rd(8'h38, 32'h0001000A);
      chk(pad_out, 32'h0001000A);
      ext_level <= 32'hFF000300;
      rd(8'h3C, 32'h00010300);
      wr(8'hA0, 32'h0000000F);
      rd(8'hA8, 32'h0000000F);
      wr(8'h38, 32'hFFFFFFF0);
      rd(8'h38, 32'h00010000);
      wr(8'h38, 32'h00000006);
      rd(8'h38, 32'h00010006);
      $display("test drive level done");
      // Drain events left by earlier pin moves
      acc(8'h4C, 1'b0, 32'h00000000);
      wr(8'h40, 32'h00000300);
      wr(8'h44, 32'h00000200);
      rd(8'h48, 32'h00000100);
      ext_level <= 32'hFF000000;
      repeat (6) @(posedge clk);
      chk({31'h0, irq}, 32'h00000001);
      rd(8'h4C, 32'h00000300);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h00000000);
      rd(8'h4C, 32'h00000000);
      ext_level <= 32'hFF000200;
      repeat (6) @(posedge clk);
      chk({31'h0, irq}, 32'h00000000);
      wr(8'h40, 32'h00000200);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h00000001);
      rd(8'h4C, 32'h00000200);
      acc(8'h50, 1'b1, 32'hFFFFFFFF);
      chk({31'h0, e}, 32'h00000001);
      acc(8'h50, 1'b0, 32'h00000000);
      chk(r, 32'h00000000);
      $display("test interrupt done");
      // Line 6 is filtered: a one-cycle pulse must not count as a change
      wr(8'h40, 32'h00000040);
      ext_level <= 32'hFF000240;
      @(posedge clk);
      ext_level <= 32'hFF000200;
      repeat (14) @(posedge clk);
      chk({31'h0, irq}, 32'h00000000);
      ext_level <= 32'hFF000240;
      repeat (14) @(posedge clk);
      chk({31'h0, irq}, 32'h00000001);
      wr(8'h4C, 32'h00000040);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h00000000);
      rd(8'h4C, 32'h00000000);
      // Filter off again: a one-cycle low pulse now shows up
      wr(8'h24, 32'h00000040);
      ext_level <= 32'hFF000200;
      @(posedge clk);
      ext_level <= 32'hFF000240;
      repeat (6) @(posedge clk);
      rd(8'h4C, 32'h00000040);
      $display("test glitch filter done");
      stop_test();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clk);
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      stop_test();
   end
endmodule : io_line_output_filter_irq_regs_tb
